// File: sprsm_consts.svh
// Behaviour
// - as master drive the out-to-slave data line, as slave read it; MSB first
// - as master, out-to-slave line carries the shift register MSB in all modes
// - as master sample the in-from-slave line, as slave drive it; MSB first
// - in-from-slave line released when disabled or unselected 4-wire slave
// - 3-wire slave always drives in-from-slave line with shift register MSB
// - master makes the serial clock; slave takes it as an input
// - 4-wire slave with select high ignores all serial clock activity
// - select mode 00 is 3-wire, select unused, slave always selected
// - select mode 01 is 4-wire, select is an input choosing the slave
// - master in mode 01 drops master role on select falling edge
// - select mode 1x drives select out at the level of the low mode bit
// - select not routed to a pin in 3-wire mode, routed otherwise
// - every transfer is full duplex on one serial clock
// - mode fault clears master and unit enable and sets the fault flag
// - slave sets done flag after eight bits and stores received byte unless an unread one is held
// - 4-wire slave resets its bit counter on each select falling edge
`ifndef SPRSM_CONSTS_SVH
`define SPRSM_CONSTS_SVH

// ====================================================================
// register offsets (byte addresses)
`define SPRSM_CTRL_OFS 4'h0
`define SPRSM_STAT_OFS 4'h4
`define SPRSM_DATA_OFS 4'h8

// ====================================================================
// control fields
`define SPRSM_CTRL_UEN 0
`define SPRSM_CTRL_MEN 1
`define SPRSM_CTRL_MD_LO 2
`define SPRSM_CTRL_MD_HI 3
`define SPRSM_MD_RST 2'h1
`define SPRSM_MD_3W 2'h0
`define SPRSM_MD_4W_IN 2'h1

// ====================================================================
// status fields, write one to clear except busy, which is read-only
`define SPRSM_ST_DONE 0
`define SPRSM_ST_MODE_FAULT_FLAG 1
`define SPRSM_ST_WCOL 2
`define SPRSM_ST_OVR 3
`define SPRSM_ST_BUSY 4

// ====================================================================
// bus responses and timing
`define SPRSM_RESP_OKAY 2'h0
`define SPRSM_RESP_SLVERR 2'h2
`define SPRSM_CLK_NS 50
`define SPRSM_SCK_HALF_NS 200
`define SPRSM_SCK_HALF_CYC \
    ((`SPRSM_SCK_HALF_NS + `SPRSM_CLK_NS - 1) / `SPRSM_CLK_NS)

`endif

// File: sprsm_peer.sv
`timescale 1ns/1ns
// ========
// peer on the link: slave to the unit, or master of it
module sprsm_peer (
    // resolved pin levels
    input wire logic sck_pin,
    input wire logic mosi_pin,
    input wire logic miso_pin,
    // high while the unit drives the serial clock
    input wire logic unit_master,
    // peer drive values, used where the unit releases a pin
    output logic sck_drv,
    output logic mosi_drv,
    output logic miso_drv,
    output logic nss_drv
);
    logic [7:0] sh;
    logic cap;
    logic act;

    initial begin
        sh = 8'h00;
        cap = 1'h0;
        act = 1'h0;
        sck_drv = 1'h0;
        nss_drv = 1'h1;
    end

    // sample on the rise, shift on the fall, msb first
    always @(posedge sck_pin) begin
        cap = unit_master ? mosi_pin : miso_pin;
    end
    always @(negedge sck_pin) begin
        sh = {sh[6:0], cap};
    end
    // released lines show the inverse so a stale value cannot pass
    assign mosi_drv = act ? sh[7] : ~sh[7];
    assign miso_drv = unit_master ? sh[7] : ~sh[7];

    // ========
    // peer as master: select if asked, then nb clock pulses
    task automatic xfer(input logic [7:0] tx, input logic sel, input int nb);
        // step off the clock edge so the synchroniser sees no race
        #5;
        sh = tx;
        act = 1'h1;
        nss_drv = !sel;
        // select leads the first edge by about nine clocks
        #258;
        repeat (nb) begin
            #200 sck_drv = 1'h1;
            #200 sck_drv = 1'h0;
        end
        #200 nss_drv = 1'h1;
        act = 1'h0;
        #400;
    endtask
endmodule // sprsm_peer

// File: sprsm_pkg.sv
// ====================================================================
// types of the serial port unit
package sprsm_pkg;

    typedef enum logic {
        SPRSM_IDLE,
        SPRSM_XFER
    } sprsm_xfer_t;

    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic sck_d;
        logic nss_d;
        logic unit_en;
        logic master_en;
        logic [1:0] nss_mode;
        logic done;
        logic mode_fault_flag;
        logic wcol;
        logic ovr;
        logic [7:0] tx_buf;
        logic tx_full;
        logic [7:0] sh;
        logic capt;
        logic [3:0] bitcnt;
        logic sh_full;
        logic [7:0] rx_buf;
        logic rx_full;
        sprsm_xfer_t state;
        logic [2:0] div;
        logic sck_o;
        logic awready;
        logic wready;
        logic aw_ok;
        logic w_ok;
        logic [3:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic mosi_o;
        logic mosi_oe_n;
        logic miso_o;
        logic miso_oe_n;
        logic sck_out;
        logic sck_oe_n;
        logic nss_o;
        logic nss_oe_n;
        logic nss_mapped;
    } sprsm_state_t;

endpackage

// File: sprsm_props.sv
`timescale 1ns/1ns
// ========
// pin-level checks of the serial port unit
module sprsm_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins
    input wire logic mosi_out,
    input wire logic mosi_oe_n,
    input wire logic miso_oe_n,
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic nss_in,
    input wire logic nss_oe_n,
    input wire logic nss_pin_mapped
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ========
    // sequences
    // one high phase of the serial clock, four system clocks
    sequence sck_high_s;
        sck_out [*4] ##1 !sck_out;
    endsequence
    // select input held high long enough to pass the synchroniser
    sequence nss_idle_s;
        (nss_pin_mapped && nss_oe_n && nss_in) [*5];
    endsequence

    // ========
    // assertions
    rst_release_a: assert property ($rose(rst_n) |->
        mosi_oe_n && miso_oe_n && sck_oe_n && nss_oe_n)
        else $error("pins driven right after reset");
    nss_route_a: assert property (!nss_oe_n |-> nss_pin_mapped)
        else $error("select driven but not routed");
    master_miso_a: assert property (!sck_oe_n |-> miso_oe_n)
        else $error("master drives the slave data line");
    clk_owner_a: assert property (mosi_oe_n == sck_oe_n)
        else $error("clock and data drive disagree");
    unsel_hiz_a: assert property (nss_idle_s |-> miso_oe_n)
        else $error("unselected slave drives its data line");
    fault_drop_a: assert property (
        !mosi_oe_n && nss_oe_n && nss_pin_mapped && $fell(nss_in)
        |-> ##[1:6] (mosi_oe_n && sck_oe_n))
        else $error("master kept the bus after select fell");
    mosi_hold_a: assert property (
        !mosi_oe_n && sck_out && $past(sck_out) |-> $stable(mosi_out))
        else $error("data changed while serial clock high");
    // an abort releases the clock pin, so the phase check stops there
    sck_half_a: assert property (disable iff (!rst_n || sck_oe_n)
        $rose(sck_out) |-> sck_high_s)
        else $error("serial clock high phase wrong length");
endmodule // sprsm_props

bind sprsm_top sprsm_props u_props (.clk, .rst_n, .mosi_out, .mosi_oe_n,
    .miso_oe_n, .sck_out, .sck_oe_n, .nss_in, .nss_oe_n, .nss_pin_mapped);

// File: sprsm_top.sv
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "sprsm_consts.svh"

module sprsm_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // axi4-lite write address and data
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // master-out slave-in data pin
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    // master-in slave-out data pin
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n,
    // serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    // slave select pin and its routing
    input wire logic nss_in,
    output logic nss_out,
    output logic nss_oe_n,
    output logic nss_pin_mapped
);
    import sprsm_pkg::*;

    localparam logic [2:0] HALF_LAST = 3'(`SPRSM_SCK_HALF_CYC - 1);

    sprsm_state_t s;
    sprsm_state_t next_s;

    // ================================================================
    // register decode helpers
    function automatic logic addr_ok(input logic [3:0] a);
        addr_ok = (a == `SPRSM_CTRL_OFS) || (a == `SPRSM_STAT_OFS) ||
                  (a == `SPRSM_DATA_OFS);
    endfunction

    function automatic logic [31:0] read_word(input logic [3:0] a,
                                              input sprsm_state_t st);
        read_word = 32'h0000_0000;
        if (a == `SPRSM_CTRL_OFS) begin
            read_word[`SPRSM_CTRL_UEN] = st.unit_en;
            read_word[`SPRSM_CTRL_MEN] = st.master_en;
            read_word[`SPRSM_CTRL_MD_HI:`SPRSM_CTRL_MD_LO] = st.nss_mode;
        end else if (a == `SPRSM_STAT_OFS) begin
            read_word[`SPRSM_ST_DONE] = st.done;
            read_word[`SPRSM_ST_MODE_FAULT_FLAG] = st.mode_fault_flag;
            read_word[`SPRSM_ST_WCOL] = st.wcol;
            read_word[`SPRSM_ST_OVR] = st.ovr;
            read_word[`SPRSM_ST_BUSY] = (st.state == SPRSM_XFER) ||
                                        (st.bitcnt != 4'h0);
        end else if (a == `SPRSM_DATA_OFS) begin
            read_word[7:0] = st.rx_buf;
        end
    endfunction

    // ================================================================
    // next state
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic nss_s;
    logic nss_fall;
    logic sck_rise;
    logic sck_fall;
    logic slave_sel;
    logic wr_go;

    always_comb begin
        next_s = s;
        // pins cross in through two flops; only sync2 is looked at
        next_s.sync1 = {sck_in, mosi_in, miso_in, nss_in};
        next_s.sync2 = s.sync1;
        sck_s = s.sync2[3];
        mosi_s = s.sync2[2];
        miso_s = s.sync2[1];
        nss_s = s.sync2[0];
        next_s.sck_d = sck_s;
        next_s.nss_d = nss_s;
        nss_fall = s.nss_d & ~nss_s;
        sck_rise = ~s.sck_d & sck_s;
        sck_fall = s.sck_d & ~sck_s;
        // 1x as slave is off-recommendation; it behaves like 3-wire
        slave_sel = (s.nss_mode != `SPRSM_MD_4W_IN) || !nss_s;

        // write address and data are caught in either order
        if (s_axi_awvalid && s.awready) begin
            next_s.aw_ok = 1'b1;
            next_s.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready) begin
            next_s.w_ok = 1'b1;
            next_s.wdata = s_axi_wdata[7:0];
            next_s.wstrb0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        wr_go = next_s.aw_ok && next_s.w_ok && !next_s.bvalid;
        if (wr_go) begin
            next_s.aw_ok = 1'b0;
            next_s.w_ok = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = addr_ok(next_s.awaddr) ? `SPRSM_RESP_OKAY :
                                                    `SPRSM_RESP_SLVERR;
            if (next_s.wstrb0) begin
                unique case (next_s.awaddr)
                    `SPRSM_CTRL_OFS: begin
                        next_s.unit_en = next_s.wdata[`SPRSM_CTRL_UEN];
                        next_s.master_en = next_s.wdata[`SPRSM_CTRL_MEN];
                        next_s.nss_mode =
                            next_s.wdata[`SPRSM_CTRL_MD_HI:`SPRSM_CTRL_MD_LO];
                    end
                    `SPRSM_STAT_OFS: begin
                        if (next_s.wdata[`SPRSM_ST_DONE]) next_s.done = 1'b0;
                        if (next_s.wdata[`SPRSM_ST_MODE_FAULT_FLAG]) next_s.mode_fault_flag = 1'b0;
                        if (next_s.wdata[`SPRSM_ST_WCOL]) next_s.wcol = 1'b0;
                        if (next_s.wdata[`SPRSM_ST_OVR]) next_s.ovr = 1'b0;
                    end
                    `SPRSM_DATA_OFS: begin
                        // a full transmit buffer refuses the byte
                        if (s.tx_full) begin
                            next_s.wcol = 1'b1;
                        end else begin
                            next_s.tx_buf = next_s.wdata;
                            next_s.tx_full = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // read answers one cycle after the address is taken
        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s.arready) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = read_word(s_axi_araddr, s);
            next_s.rresp = addr_ok(s_axi_araddr) ? `SPRSM_RESP_OKAY :
                                                   `SPRSM_RESP_SLVERR;
            if (s_axi_araddr == `SPRSM_DATA_OFS) next_s.rx_full = 1'b0;
        end

        // serial engine; hardware sets come last so they beat clears
        if (!s.unit_en) begin
            // disabling is the only way to realign a 3-wire slave
            next_s.state = SPRSM_IDLE;
            next_s.bitcnt = 4'h0;
            next_s.sck_o = 1'b0;
            next_s.div = 3'h0;
            next_s.sh_full = 1'b0;
        end else if (s.master_en) begin
            if (s.nss_mode == `SPRSM_MD_4W_IN && nss_fall) begin
                next_s.unit_en = 1'b0;
                next_s.master_en = 1'b0;
                next_s.mode_fault_flag = 1'b1;
                next_s.state = SPRSM_IDLE;
                next_s.sck_o = 1'b0;
                next_s.bitcnt = 4'h0;
            end else begin
                unique case (s.state)
                    SPRSM_IDLE: begin
                        if (s.tx_full) begin
                            next_s.sh = s.tx_buf;
                            next_s.tx_full = 1'b0;
                            next_s.div = 3'h0;
                            next_s.state = SPRSM_XFER;
                        end
                    end
                    SPRSM_XFER: begin
                        if (s.div == HALF_LAST) begin
                            next_s.div = 3'h0;
                            if (!s.sck_o) begin
                                next_s.sck_o = 1'b1;
                                next_s.capt = miso_s;
                            end else begin
                                next_s.sck_o = 1'b0;
                                next_s.sh = {s.sh[6:0], s.capt};
                                next_s.bitcnt = s.bitcnt + 4'h1;
                                if (s.bitcnt == 4'h7) begin
                                    next_s.bitcnt = 4'h0;
                                    next_s.done = 1'b1;
                                    next_s.rx_buf = {s.sh[6:0], s.capt};
                                    next_s.rx_full = 1'b1;
                                    next_s.state = SPRSM_IDLE;
                                end
                            end
                        end else begin
                            next_s.div = s.div + 3'h1;
                        end
                    end
                endcase
            end
        end else if (s.nss_mode == `SPRSM_MD_4W_IN && nss_fall) begin
            next_s.bitcnt = 4'h0;
        end else if (slave_sel) begin
            if (sck_rise) next_s.capt = mosi_s;
            if (sck_fall) begin
                next_s.sh = {s.sh[6:0], s.capt};
                next_s.sh_full = 1'b1;
                next_s.bitcnt = s.bitcnt + 4'h1;
                if (s.bitcnt == 4'h7) begin
                    next_s.bitcnt = 4'h0;
                    next_s.done = 1'b1;
                    // unread byte is kept; the new one is lost
                    if (next_s.rx_full) begin
                        next_s.ovr = 1'b1;
                    end else begin
                        next_s.rx_buf = {s.sh[6:0], s.capt};
                        next_s.rx_full = 1'b1;
                    end
                    next_s.sh_full = s.tx_full;
                    if (s.tx_full) begin
                        next_s.sh = s.tx_buf;
                        next_s.tx_full = 1'b0;
                    end
                end
            end else if (!s.sh_full && s.tx_full && s.bitcnt == 4'h0) begin
                next_s.sh = s.tx_buf;
                next_s.tx_full = 1'b0;
                next_s.sh_full = 1'b1;
            end
        end

        // write readies re-arm once their own capture and the response clear; read ready once rvalid drops
        next_s.awready = !next_s.aw_ok && !next_s.bvalid;
        next_s.wready = !next_s.w_ok && !next_s.bvalid;
        next_s.arready = !next_s.rvalid;

        // pin drive, registered so every output leaves a flop
        next_s.mosi_o = next_s.sh[7];
        next_s.mosi_oe_n = !(next_s.unit_en && next_s.master_en);
        next_s.sck_out = next_s.sck_o;
        next_s.sck_oe_n = !(next_s.unit_en && next_s.master_en);
        next_s.miso_o = next_s.sh[7];
        next_s.miso_oe_n = !(next_s.unit_en && !next_s.master_en &&
                             slave_sel);
        next_s.nss_o = next_s.nss_mode[0];
        next_s.nss_oe_n = !next_s.nss_mode[1];
        next_s.nss_mapped = next_s.nss_mode != `SPRSM_MD_3W;
    end

    // ================================================================
    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
            s.nss_mode <= `SPRSM_MD_RST;
            s.mosi_oe_n <= 1'b1;
            s.miso_oe_n <= 1'b1;
            s.sck_oe_n <= 1'b1;
            s.nss_oe_n <= 1'b1;
            s.nss_o <= 1'b1;
            s.nss_mapped <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ================================================================
    // outputs
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign mosi_out = s.mosi_o;
    assign mosi_oe_n = s.mosi_oe_n;
    assign miso_out = s.miso_o;
    assign miso_oe_n = s.miso_oe_n;
    assign sck_out = s.sck_out;
    assign sck_oe_n = s.sck_oe_n;
    assign nss_out = s.nss_o;
    assign nss_oe_n = s.nss_oe_n;
    assign nss_pin_mapped = s.nss_mapped;

endmodule // sprsm_top

// File: tb.sv
`timescale 1ns/1ns
// ========
// self-checking bench of the serial port unit
module tb;
    logic clk, rst_n, awv, awr, wv, wrd, bv, arv, arr, rv;
    logic [3:0] awa, ara;
    logic [31:0] wd, rdat, rnd, d;
    logic [1:0] br, rr, r;
    logic mosi_out, mosi_oe_n, miso_out, miso_oe_n, sck_out, sck_oe_n;
    logic nss_out, nss_oe_n, nss_pin_mapped;
    logic sck_drv, mosi_drv, miso_drv, nss_drv;
    int mismatches, total_checks;
    int mm[3] = '{0, 2, 3};
    logic [7:0] exp_q[$];

    // whoever has its enable low owns the wire
    wire sck_w = !sck_oe_n ? sck_out : sck_drv;
    wire mosi_w = !mosi_oe_n ? mosi_out : mosi_drv;
    wire miso_w = !miso_oe_n ? miso_out : miso_drv;
    wire nss_w = !nss_oe_n ? nss_out : nss_drv;
    wire [3:0] oe_w = {mosi_oe_n, miso_oe_n, sck_oe_n, nss_oe_n};

    sprsm_top uut (
        .clk, .rst_n,
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(1'h1),
        .mosi_in(mosi_w), .mosi_out, .mosi_oe_n, .miso_in(miso_w),
        .miso_out, .miso_oe_n, .sck_in(sck_w), .sck_out, .sck_oe_n,
        .nss_in(nss_w), .nss_out, .nss_oe_n, .nss_pin_mapped
    );
    sprsm_peer peer (.sck_pin(sck_w), .mosi_pin(mosi_w), .miso_pin(miso_w),
        .unit_master(!sck_oe_n), .sck_drv, .mosi_drv, .miso_drv, .nss_drv);

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    // ========
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results;
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // a wait that used up its bound ends the run
    task automatic stuck(input int n);
        if (n >= 200) begin
            mismatches++;
            $display("Error answer expected 1 seen 0");
            results;
        end
    endtask

    // ready lines stay high, so only valid needs holding
    task automatic wr(input logic [3:0] a, input logic [31:0] v,
        output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk);
        awa <= a;
        wd <= v;
        awv <= 1'h1;
        wv <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (awr) awv <= 1'h0;
            if (wrd) wv <= 1'h0;
            rs = br;
        end while (!bv && n < 200);
        stuck(n);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v,
        output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk);
        ara <= a;
        arv <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (arr) arv <= 1'h0;
            v = rdat;
            rs = rr;
        end while (!rv && n < 200);
        stuck(n);
    endtask

    // poll the done flag, then clear it
    task automatic wait_done;
        logic [31:0] s;
        logic [1:0] rs;
        s = 32'h0;
        for (int i = 0; i < 60 && s[0] !== 1'h1; i++) rd(4'h4, s, rs);
        if (s[0] !== 1'h1) stuck(200);
        wr(4'h4, 32'h1, rs);
    endtask

    // ========
    // main sequence
    initial begin
        rst_n <= 1'h0;
        awv <= 1'h0;
        wv <= 1'h0;
        arv <= 1'h0;
        awa <= 4'h0;
        ara <= 4'h0;
        wd <= 32'h0;
        rnd = 32'h95241462;
        mismatches = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        chk("pins", 32'(oe_w), 32'hF);
        rd(4'h0, d, r);
        chk("ctrl", d, 32'h4);
        rd(4'hC, d, r);
        chk("bad_addr", 32'(r), 32'h2);
        wr(4'hC, 32'h1, r);
        chk("bad_wr", 32'(r), 32'h2);
        // every select mode with the unit off
        for (int m = 0; m < 4; m++) begin
            wr(4'h0, 32'(m) << 2, r);
            chk("wr_ok", 32'(r), 32'h0);
            repeat (2) @(posedge clk);
            chk("routed", 32'(nss_pin_mapped), 32'(m != 0));
            chk("nss_dir", 32'(nss_oe_n), 32'(m < 2));
            if (m > 1) chk("nss_lvl", 32'(nss_out), 32'(m % 2));
            chk("miso_off", 32'(miso_oe_n), 32'h1);
        end
        // unit as master in select modes 00, 10 and 11; 1x only while master
        foreach (mm[i]) begin
            wr(4'h0, 32'h3 | (32'(mm[i]) << 2), r);
            rnd = lfsr(rnd);
            peer.sh = rnd[15:8];
            exp_q.push_back(rnd[15:8]);
            wr(4'h8, 32'(rnd[7:0]), r);
            repeat (8) @(posedge clk);
            chk("oe", 32'(oe_w), 32'h4 | 32'(mm[i] < 2));
            wait_done;
            chk("peer_rx", 32'(peer.sh), 32'(rnd[7:0]));
            rd(4'h8, d, r);
            chk("m_rx", d, 32'(exp_q.pop_front()));
        end
        // unit as selected 4-wire slave
        wr(4'h0, 32'h5, r);
        rnd = lfsr(rnd);
        wr(4'h8, 32'(rnd[7:0]), r);
        exp_q.push_back(rnd[15:8]);
        peer.xfer(rnd[15:8], 1'h1, 8);
        wait_done;
        chk("s_tx", 32'(peer.sh), 32'(rnd[7:0]));
        rd(4'h8, d, r);
        chk("s_rx", d, 32'(exp_q.pop_front()));
        // clocks with select high must leave no trace
        peer.xfer(8'hFF, 1'h0, 8);
        chk("miso_hiz", 32'(miso_oe_n), 32'h1);
        rd(4'h4, d, r);
        chk("ignored", 32'(d[0]), 32'h0);
        // a broken frame must not shift the next byte
        peer.xfer(8'h00, 1'h1, 3);
        rnd = lfsr(rnd);
        peer.xfer(rnd[7:0], 1'h1, 8);
        wait_done;
        rd(4'h8, d, r);
        chk("resync", d, 32'(rnd[7:0]));
        // 3-wire slave: always selected, data line always driven
        wr(4'h0, 32'h0, r);
        wr(4'h0, 32'h1, r);
        repeat (2) @(posedge clk);
        chk("miso_on", 32'(miso_oe_n), 32'h0);
        rnd = lfsr(rnd);
        wr(4'h8, 32'(rnd[7:0]), r);
        peer.xfer(rnd[15:8], 1'h0, 8);
        wait_done;
        chk("w3_tx", 32'(peer.sh), 32'(rnd[7:0]));
        rd(4'h8, d, r);
        chk("w3_rx", d, 32'(rnd[15:8]));
        // another master takes the bus mid transfer
        wr(4'h0, 32'h7, r);
        wr(4'h8, 32'h3C, r);
        peer.xfer(8'h00, 1'h1, 0);
        chk("oe_fault", 32'(oe_w), 32'hF);
        rd(4'h0, d, r);
        chk("ctrl_fault", d, 32'h4);
        rd(4'h4, d, r);
        chk("flag_fault", 32'(d[1]), 32'h1);
        results;
    end
endmodule // tb
